// ===== design/rab_pkg.sv
package rab_pkg;
	localparam int CLK_NS = 100;
	localparam int US_NS = 1000;
	localparam int US_CYC = US_NS / CLK_NS;
	localparam int TONE_MIN_US = 16;
	localparam int TONE_MAX_US = 160;
	localparam int TONE_UNIT_US = 8;
	localparam int TU_MIN = TONE_MIN_US / TONE_UNIT_US;
	localparam int TU_MAX = TONE_MAX_US / TONE_UNIT_US;
	localparam int GUARD_US = 4;
	localparam int REF_US = 8;
	localparam int ADDR_BITS = 48;
	localparam int N_ENT = 8;
	localparam int TX_ADDRESS_TYPE_BIT_BIT = 6;
	localparam int CP_BIT = 5;
	localparam int ADV_FLAG_BIT = 2;
	localparam int ADV_INFO_BYTE = 2;
	localparam int ADV_SKIP = 6;
	localparam int SCAN_LEN = 2 * N_ENT;
	// register word indices, byte address is four times the index
	localparam logic [4:0] R_TASK = 5'h00;
	localparam logic [4:0] R_EVT = 5'h01;
	localparam logic [4:0] R_BCC = 5'h02;
	localparam logic [4:0] R_BCNT = 5'h03;
	localparam logic [4:0] R_DACFG = 5'h04;
	localparam logic [4:0] R_MSTAT = 5'h05;
	localparam logic [4:0] R_PCFG = 5'h06;
	localparam logic [4:0] R_INL = 5'h07;
	localparam logic [4:0] R_SPC = 5'h08;
	localparam logic [4:0] R_TSTAT = 5'h09;
	// 0x10..0x17 low words, 0x18..0x1F high halves
	localparam logic [4:0] R_ADDR = 5'h10;
	localparam int T_BITCOUNTER_START_TASK = 0;
	localparam int T_BITCOUNTER_STOP_TASK = 1;
	localparam int PCFG_LE = 0;
	localparam int PCFG_RATE = 1;
	localparam int PCFG_DFM = 3;
	localparam int INL_EN = 0;
	localparam int INL_DATA = 1;
	localparam int INL_MASK = 8;
	localparam int INL_CMP = 16;
	localparam int INL_RANGE = 24;
	localparam int SPC_REF = 0;
	localparam int SPC_SLOT = 4;
	localparam int SPC_SHORT = 8;
	localparam int SPC_LONG = 12;
	localparam int SPC_MANLEN = 16;
	localparam int SPC_MAN2US = 24;
	localparam logic [31:0] INL_RST = 32'h1400_0000;
	localparam logic [31:0] SPC_RST = 32'h0002_0000;
	localparam logic [1:0] RATE_1M = 2'h0;
	localparam logic [1:0] RATE_2M = 2'h1;
	localparam logic [1:0] DFM_AOA = 2'h1;
	localparam logic [1:0] DFM_AOD = 2'h2;
	localparam logic [1:0] TYPE_1US = 2'h1;
	localparam logic [1:0] TYPE_2US = 2'h2;

	typedef enum logic [2:0] {FLD_IDLE, FLD_HDR0, FLD_LEN, FLD_HDR1, FLD_PAY, FLD_CRC} rab_field_t;
	typedef enum logic [2:0] {TS_IDLE, TS_GUARD, TS_REF, TS_SWITCH, TS_SAMPLE} rab_ts_t;

	typedef struct packed {
		logic rx;
		logic tx;
		logic bit_stb;
		logic bit_val;
		rab_field_t field;
		logic addr_evt;
		logic end_evt;
		logic disabled_evt;
		logic stop_task;
		logic disable_task;
		logic crc_end;
	} rab_air_t;

	typedef struct packed {
		logic tone_on;
		logic tone_bit;
		logic ant_switch;
		logic iq_sample;
		logic tone_present;
	} rab_dfe_t;

	typedef struct packed {
		logic [1:0] bus_ph;
		logic [31:0] rdata;
		logic [15:0] bcc;
		logic [15:0] bcnt;
		logic bc_run;
		logic ev_bcm;
		logic ev_dam;
		logic ev_cte;
		logic [15:0] dacfg;
		logic [7:0] mvec;
		logic [5:0] pcfg;
		logic [31:0] inl;
		logic [31:0] spc;
		rab_field_t fld;
		logic [2:0] fb;
		logic [7:0] sh;
		logic [7:0] s0;
		logic tx_address_type_bit;
		logic [6:0] pb;
		logic [47:0] asr;
		logic [5:0] elen;
		logic [7:0] flags;
		logic scan;
		logic [4:0] scnt;
		logic low_ok;
		logic info_ok;
		logic [7:0] info;
		rab_ts_t ts;
		logic [3:0] udiv;
		logic [7:0] ucnt;
		logic [7:0] len;
		logic [7:0] seg;
		logic [4:0] sdiv;
		logic [4:0] sspc;
		logic slot2;
		logic gen;
		logic sw;
		logic smp;
		rab_dfe_t dfe;
		logic bcm_p;
		logic dam_p;
	} rab_st_t;
endpackage

// ===== design/rab_mem.sv
`timescale 1ns/1ps
module rab_mem #(
	parameter int W = 32,
	parameter int D = 16,
	parameter int AW = 4
) (
	input wire logic clock,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [D];

	// no reset on the array: entries are undefined until software writes them
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ===== design/rab_core.sv
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rab_core
	import rab_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire rab_air_t air,
	output rab_dfe_t dfe,
	output logic bc_match_evt,
	output logic addr_match_evt
);
	rab_st_t st;
	rab_st_t n;
	logic req;
	logic acc;
	logic bcs;
	logic bcp;
	logic stop_any;
	logic rate_ok;
	logic mask_ok;
	logic [3:0] raddr;
	logic [31:0] mem_q;

	function automatic logic [4:0] spc_cyc(input logic [4:0] base, input logic [1:0] code);
		logic [4:0] v;
		v = base >> code;
		return (v == 5'h00) ? 5'h01 : v;
	endfunction

	function automatic logic [7:0] seg_len(input rab_ts_t s, input logic two);
		if (s == TS_GUARD) return 8'(GUARD_US);
		if (s == TS_REF) return 8'(REF_US);
		return two ? 8'h02 : 8'h01;
	endfunction

	function automatic logic [31:0] rd_mux(input rab_st_t s, input logic [4:0] a);
		unique case (a)
			R_EVT: rd_mux = {29'h0, s.ev_cte, s.ev_dam, s.ev_bcm};
			R_BCC: rd_mux = {16'h0, s.bcc};
			R_BCNT: rd_mux = {15'h0, s.bc_run, s.bcnt};
			R_DACFG: rd_mux = {16'h0, s.dacfg};
			R_MSTAT: rd_mux = {23'h0, s.scan, s.mvec};
			R_PCFG: rd_mux = {26'h0, s.pcfg};
			R_INL: rd_mux = s.inl;
			R_SPC: rd_mux = s.spc;
			R_TSTAT: rd_mux = {17'h0, s.ts, s.info_ok, 3'h0, s.info};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	assign req = read | write;
	// extra wait states while the matcher owns the address memory
	assign waitrequest = req & (st.bus_ph != 2'h2);
	assign acc = req & (st.bus_ph == 2'h2);
	assign readdata = st.rdata;
	assign bcs = acc & write & (address == R_TASK) & writedata[T_BITCOUNTER_START_TASK];
	assign bcp = acc & write & (address == R_TASK) & writedata[T_BITCOUNTER_STOP_TASK];
	assign stop_any = bcp | air.stop_task | air.disable_task | air.end_evt | air.disabled_evt;
	assign rate_ok = (st.pcfg[PCFG_RATE+:2] == RATE_1M) || (st.pcfg[PCFG_RATE+:2] == RATE_2M);
	assign mask_ok = (st.s0 & st.inl[INL_MASK+:8]) == st.inl[INL_CMP+:8];
	assign raddr = st.scan ? {st.scnt[0], st.scnt[3:1]} : address[3:0];
	assign dfe = st.dfe;
	assign bc_match_evt = st.bcm_p;
	assign addr_match_evt = st.dam_p;

	rab_mem #(.W(32), .D(SCAN_LEN), .AW(4)) u_mem (
		.clock(clock),
		.we(acc & write & address[4]),
		.waddr(address[3:0]),
		.wdata(writedata),
		.raddr(raddr),
		.rdata(mem_q)
	);

	always_comb begin
		logic [7:0] byt;
		logic [2:0] cfb;
		logic [4:0] e;
		logic [4:0] tu;
		logic [1:0] code;
		logic [4:0] cur;
		logic tick;
		byt = {air.bit_val, st.sh[7:1]};
		cfb = (air.field == st.fld) ? st.fb + 3'h1 : 3'h0;
		e = st.scnt - 5'h01;
		tu = 5'h00;
		code = 2'h0;
		cur = 5'h00;
		tick = 1'b0;
		n = st;
		n.bcm_p = 1'b0;
		n.dam_p = 1'b0;
		n.dfe.ant_switch = 1'b0;
		n.dfe.iq_sample = 1'b0;
		n.dfe.tone_present = 1'b0;

		if (acc) begin
			n.bus_ph = 2'h0;
		end else if (st.bus_ph == 2'h1) begin
			n.bus_ph = 2'h2;
			n.rdata = address[4] ? mem_q : rd_mux(st, address);
		end else if (req && !st.scan) begin
			n.bus_ph = 2'h1;
		end
		if (acc && write && !address[4]) begin
			unique case (address)
				R_EVT: begin
					n.ev_bcm = st.ev_bcm & ~writedata[0];
					n.ev_dam = st.ev_dam & ~writedata[1];
					n.ev_cte = st.ev_cte & ~writedata[2];
				end
				R_BCC: n.bcc = writedata[15:0];
				R_DACFG: n.dacfg = writedata[15:0];
				R_PCFG: n.pcfg = writedata[5:0];
				R_INL: n.inl = writedata;
				R_SPC: n.spc = writedata;
				default: ;
			endcase
		end

		// start is honoured unless a stop arrives in the same cycle; ordering after the address event is software's job
		if (stop_any) begin
			n.bc_run = 1'b0;
			n.bcnt = 16'h0000;
		end else if (bcs) begin
			n.bc_run = 1'b1;
			n.bcnt = 16'h0000;
		end else if (st.bc_run && air.bit_stb) begin
			n.bcnt = st.bcnt + 16'h0001;
			if (n.bcnt == st.bcc) begin
				n.bcm_p = 1'b1;
				n.ev_bcm = 1'b1;
			end
			// counter stays running past the match
		end

		if (air.addr_evt) begin
			n.pb = 7'h00;
			n.mvec = 8'h00;
			n.info_ok = 1'b0;
			n.elen = 6'h00;
			n.flags = 8'h00;
		end else if (air.rx && air.bit_stb) begin
			n.fld = air.field;
			n.fb = cfb;
			n.sh = byt;
			if (air.field == FLD_HDR0 && cfb == 3'h7) begin
				n.s0 = byt;
				n.tx_address_type_bit = byt[TX_ADDRESS_TYPE_BIT_BIT];
			end
			// header1 follows an 8-bit length after a one-byte header0
			if (air.field == FLD_HDR1 && cfb == 3'h7 && st.inl[INL_DATA] && mask_ok &&
				st.s0[CP_BIT]) begin
				n.info = byt;
				n.info_ok = st.inl[INL_EN] && (byt[5:0] <= st.inl[INL_RANGE+:6]);
			end
			if (air.field == FLD_PAY) begin
				n.pb = (st.pb == 7'h7F) ? st.pb : st.pb + 7'h01;
				if (st.pb < 7'(ADDR_BITS)) begin
					n.asr = {air.bit_val, st.asr[47:1]};
				end
				if (st.pb == 7'(ADDR_BITS - 1) && st.pcfg[PCFG_LE]) begin
					n.scan = 1'b1;
					n.scnt = 5'h00;
				end
				if (st.pb[2:0] == 3'h7 && !st.inl[INL_DATA] && mask_ok) begin
					if (st.pb[6:3] == 4'h0) n.elen = byt[5:0];
					if (st.pb[6:3] == 4'h1) n.flags = byt;
					if (st.elen != 6'h00 && st.flags[ADV_FLAG_BIT] &&
						st.pb[6:3] == ((st.flags[ADV_FLAG_BIT-1:0] != 2'h0) ?
						4'(ADV_INFO_BYTE + ADV_SKIP) : 4'(ADV_INFO_BYTE))) begin
						n.info = byt;
						n.info_ok = st.inl[INL_EN] && (byt[5:0] <= st.inl[INL_RANGE+:6]);
					end
				end
			end
		end
		if (n.info_ok && !st.info_ok) begin
			n.ev_cte = 1'b1;
			n.dfe.tone_present = 1'b1;
		end

		// serial scan trades 17 cycles of latency for one memory port
		if (st.scan) begin
			n.scnt = st.scnt + 5'h01;
			if (st.scnt != 5'h00) begin
				if (!e[0]) begin
					n.low_ok = (mem_q == st.asr[31:0]);
				end else if (st.low_ok && mem_q[15:0] == st.asr[47:32] && st.dacfg[e[3:1]] &&
					st.dacfg[N_ENT + 32'(e[3:1])] == st.tx_address_type_bit) begin
					n.mvec[e[3:1]] = 1'b1;
				end
			end
			if (st.scnt == 5'(SCAN_LEN)) begin
				n.scan = 1'b0;
				if (n.mvec != 8'h00) begin
					n.dam_p = 1'b1;
					n.ev_dam = 1'b1;
				end
			end
		end

		if (air.crc_end && rate_ok && st.pcfg[PCFG_DFM+:2] != 2'h0 &&
			(air.tx || (air.rx && (!st.inl[INL_EN] || st.info_ok)))) begin
			n.ts = TS_GUARD;
			n.udiv = 4'h0;
			n.ucnt = 8'h00;
			n.seg = 8'h00;
			n.sdiv = 5'h00;
			n.gen = air.tx;
			n.smp = air.rx;
			n.sw = (st.pcfg[PCFG_DFM+:2] == DFM_AOA && air.rx) ||
				(st.pcfg[PCFG_DFM+:2] == DFM_AOD && air.tx);
			n.dfe.ant_switch = n.sw;
			if (st.inl[INL_EN] && air.rx) begin
				tu = st.info[4:0];
				n.slot2 = st.info[7:6] == TYPE_2US;
				code = (st.info[7:6] == TYPE_1US) ? st.spc[SPC_SHORT+:2] :
					(st.info[7:6] == TYPE_2US) ? st.spc[SPC_LONG+:2] : st.spc[SPC_SLOT+:2];
			end else begin
				tu = st.spc[SPC_MANLEN+:5];
				n.slot2 = st.spc[SPC_MAN2US];
				code = st.spc[SPC_SLOT+:2];
			end
			if (tu < 5'(TU_MIN)) tu = 5'(TU_MIN);
			if (tu > 5'(TU_MAX)) tu = 5'(TU_MAX);
			n.len = 8'(32'(tu) * TONE_UNIT_US);
			n.sspc = spc_cyc(n.slot2 ? 5'(2 * US_CYC) : 5'(US_CYC), code);
		end else if (st.ts != TS_IDLE) begin
			tick = (st.udiv == 4'(US_CYC - 1));
			n.udiv = tick ? 4'h0 : st.udiv + 4'h1;
			if (air.stop_task || air.disable_task) begin
				n.ts = TS_IDLE;
			end else if (tick) begin
				n.ucnt = st.ucnt + 8'h01;
				n.seg = st.seg + 8'h01;
				if (n.ucnt == st.len) begin
					n.ts = TS_IDLE;
				end else if (n.seg == seg_len(st.ts, st.slot2)) begin
					n.seg = 8'h00;
					n.sdiv = 5'h00;
					n.ts = (st.ts == TS_GUARD) ? TS_REF : (st.ts == TS_SWITCH) ? TS_SAMPLE : TS_SWITCH;
					n.dfe.ant_switch = st.sw && n.ts == TS_SWITCH;
				end
			end
		end
		if (n.smp && (n.ts == TS_REF || n.ts == TS_SAMPLE)) begin
			cur = (n.ts == TS_REF) ? spc_cyc(5'(US_CYC), st.spc[SPC_REF+:2]) : n.sspc;
			if (n.sdiv == 5'h00) begin
				n.dfe.iq_sample = 1'b1;
				n.sdiv = cur - 5'h01;
			end else begin
				n.sdiv = n.sdiv - 5'h01;
			end
		end
		n.dfe.tone_on = n.ts != TS_IDLE;
		n.dfe.tone_bit = n.dfe.tone_on && n.gen;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.inl <= INL_RST;
			st.spc <= SPC_RST;
		end else begin
			st <= n;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_bc_match_value: assert property (bc_match_evt |-> st.bcnt == st.bcc && st.bc_run)
		else $error("bit match event without count equal to compare");
	a_bc_stop_clear: assert property (stop_any |=> st.bcnt == 16'h0000 && !st.bc_run)
		else $error("bit counter not cleared by stop");
	a_bc_start_zero: assert property ((bcs && !stop_any) |=> st.bc_run && st.bcnt == 16'h0000)
		else $error("bit counter start not from zero");
	a_bc_count_step: assert property ((st.bc_run && air.bit_stb && !stop_any && !bcs)
		|=> st.bc_run && st.bcnt == $past(st.bcnt) + 16'h0001)
		else $error("bit counter did not step by one");
	a_match_gate: assert property ($rose(st.scan) |-> $past(st.pcfg[PCFG_LE] && air.rx))
		else $error("address match started outside little endian receive");
	a_match_enabled: assert property (addr_match_evt |-> (st.mvec & ~st.dacfg[7:0]) == 8'h00)
		else $error("disabled entry reported as matched");
	a_scan_bound: assert property ($rose(st.scan) |-> st.scan ##[16:17] !st.scan)
		else $error("address scan length wrong");
	a_tone_rate: assert property ($rose(dfe.tone_on) |-> $past(rate_ok))
		else $error("tone started at unsupported rate");
	a_switch_place: assert property (dfe.ant_switch |-> st.ts == TS_GUARD || st.ts == TS_SWITCH)
		else $error("antenna switch outside guard or switch slot");
	a_sample_place: assert property (dfe.iq_sample |-> st.ts == TS_REF || st.ts == TS_SAMPLE)
		else $error("sample outside reference or sample slot");

	c_bc_match: cover property (bc_match_evt ##[1:40] bc_match_evt);
	c_addr_match: cover property (addr_match_evt);
	c_tone_present: cover property (dfe.tone_present ##[1:300] dfe.tone_on);
	c_switch_slot: cover property (dfe.ant_switch && st.ts == TS_SWITCH);
endmodule

// ===== bench/rab_peer.sv
`timescale 1ns/1ps
module rab_peer
	import rab_pkg::*;
(
	input wire logic clock,
	output rab_air_t air
);
	initial air = '0;
	// idle data line shows the inverse of the last bit, never a stale copy
	task automatic send_bit(input rab_field_t f, input logic v);
		@(posedge clock);
		air.bit_stb <= 1'b1;
		air.bit_val <= v;
		air.field <= f;
		@(posedge clock);
		air.bit_stb <= 1'b0;
		air.bit_val <= !v;
	endtask
	task automatic send_byte(input rab_field_t f, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			send_bit(f, b[i]);
		end
	endtask
	// 0 address event, 1 end event, 2 radio stop, 3 crc done, 4 disable task, 5 disabled event
	task automatic pulse(input int k);
		@(posedge clock);
		air.addr_evt <= (k == 0);
		air.end_evt <= (k == 1);
		air.stop_task <= (k == 2);
		air.crc_end <= (k == 3);
		air.disable_task <= (k == 4);
		air.disabled_evt <= (k == 5);
		@(posedge clock);
		air.addr_evt <= 1'b0;
		air.end_evt <= 1'b0;
		air.stop_task <= 1'b0;
		air.crc_end <= 1'b0;
		air.disable_task <= 1'b0;
		air.disabled_evt <= 1'b0;
	endtask
	task automatic mode(input logic rx, input logic tx);
		@(posedge clock);
		air.rx <= rx;
		air.tx <= tx;
	endtask
endmodule

// ===== bench/radio_rx_address_bitcount_cte_test.sv
`timescale 1ns/1ps
module radio_rx_address_bitcount_cte_test;
	import rab_pkg::*;
	typedef struct {logic [4:0] a; logic [31:0] w; logic [31:0] e;} rab_row_t;
	typedef struct {logic [5:0] pcfg; logic tx; int on; int sw; int smp;} rab_tone_t;
	localparam logic [47:0] DEV = 48'h4567_89AB_CDEF;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [4:0] address = '0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic [31:0] q;
	logic waitrequest;
	logic bc_match_evt;
	logic addr_match_evt;
	rab_air_t air;
	rab_dfe_t dfe;
	logic [6:0] evs;
	int n_mismatch = 0;
	int comparisons = 0;
	int ev[7] = '{default: 0};
	int base[7];
	rab_row_t rows[5] = '{'{R_BCC, 32'hFFFF_1234, 32'h0000_1234},
		'{R_DACFG, 32'hFFFF_A5C3, 32'h0000_A5C3}, '{5'h0A, 32'hFFFF_FFFF, 32'h0},
		'{R_BCNT, 32'hFFFF_FFFF, 32'h0}, '{R_INL, 32'h1402_AB02, 32'h1402_AB02}};
	// pcfg: rate in [2:1], mode in [4:3]
	// 16 us tone: one guard switch, two switch slots; eight reference and two slot samples
	rab_tone_t tones[6] = '{'{6'h10, 1'b1, 160, 3, 0}, '{6'h08, 1'b0, 160, 3, 10},
		'{6'h0A, 1'b1, 160, 0, 0}, '{6'h12, 1'b0, 160, 0, 10},
		'{6'h0E, 1'b1, 0, 0, 0}, '{6'h00, 1'b1, 0, 0, 0}};
	logic [7:0] hdr[4] = '{8'h20, 8'h20, 8'h00, 8'h20};
	logic [7:0] info[4] = '{8'h03, 8'h80, 8'h03, 8'h15};
	int nsm[4] = '{14, 9, 0, 0};
	int prs[4] = '{1, 1, 0, 0};
	int tlen[4] = '{240, 160, 0, 0};

	always #50 clock = ~clock;
	assign evs = {dfe.tone_present, dfe.iq_sample, dfe.ant_switch, dfe.tone_bit, dfe.tone_on,
		addr_match_evt, bc_match_evt};
	always @(posedge clock) begin
		for (int i = 0; i < 7; i++) begin
			if (evs[i] === 1'b1) ev[i]++;
		end
	end

	rab_core uut(.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .air(air),
		.dfe(dfe), .bc_match_evt(bc_match_evt), .addr_match_evt(addr_match_evt));
	rab_peer peer(.clock(clock), .air(air));

	function automatic int d(input int i);
		return ev[i] - base[i];
	endfunction
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// waitrequest read at the rising edge, before the design's registers move
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
		@(posedge clock);
		address <= a;
		writedata <= dat;
		write <= wr;
		read <= !wr;
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] dat);
		bus(1'b1, a, dat);
	endtask
	task rd_chk(input string n, input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, '0);
		check(n, q, e);
	endtask
	task addr_pkt(input logic [5:0] pcfg, input logic [15:0] cfg, input logic [7:0] exp);
		wr(R_PCFG, {26'h0, pcfg});
		wr(R_DACFG, {16'h0, cfg});
		base = ev;
		peer.pulse(0);
		peer.send_byte(FLD_HDR0, 8'h40);
		peer.send_byte(FLD_LEN, 8'h06);
		for (int i = 0; i < ADDR_BITS; i++) peer.send_bit(FLD_PAY, DEV[i]);
		repeat (SCAN_LEN + 8) @(posedge clock);
		check("addr match pulses", d(1), exp != 8'h00);
		rd_chk("match vector", R_MSTAT, {24'h0, exp});
	endtask
	task complete_run;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk("inline reset", R_INL, INL_RST);
		rd_chk("spacing reset", R_SPC, SPC_RST);
		rd_chk("compare reset", R_BCC, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd_chk("register", rows[i].a, rows[i].e);
		end
		base = ev;
		wr(R_BCC, 32'h5);
		peer.pulse(0);
		wr(R_TASK, 32'h1);
		repeat (7) peer.send_bit(FLD_PAY, 1'b1);
		check("first match", d(0), 1);
		rd_chk("running count", R_BCNT, 32'h0001_0007);
		wr(R_BCC, 32'h9);
		repeat (2) peer.send_bit(FLD_PAY, 1'b0);
		// the pulse of the last bit is counted one edge later
		repeat (2) @(posedge clock);
		check("second match", d(0), 2);
		for (int k = 1; k < 6; k++) begin
			wr(R_TASK, 32'h1);
			repeat (2) peer.send_bit(FLD_PAY, 1'b0);
			if (k == 3) wr(R_TASK, 32'h2);
			else peer.pulse(k);
			peer.send_bit(FLD_PAY, 1'b1);
			rd_chk("count cleared", R_BCNT, 32'h0);
		end
		rd_chk("event flags", R_EVT, 32'h1);
		wr(R_EVT, 32'h1);
		rd_chk("event cleared", R_EVT, 32'h0);
		wr(R_ADDR + 5'h3, DEV[31:0]);
		wr(R_ADDR + 5'hB, {16'h0, DEV[47:32]});
		peer.mode(1'b1, 1'b0);
		addr_pkt(6'h01, 16'h0808, 8'h08);
		addr_pkt(6'h00, 16'h0808, 8'h00);
		addr_pkt(6'h01, 16'h0800, 8'h00);
		addr_pkt(6'h01, 16'h0008, 8'h00);
		foreach (tones[i]) begin
			wr(R_PCFG, {26'h0, tones[i].pcfg});
			peer.mode(!tones[i].tx, tones[i].tx);
			base = ev;
			peer.pulse(3);
			repeat (300) @(posedge clock);
			check("tone cycles", d(2), tones[i].on);
			check("tone ones", d(3), tones[i].tx ? tones[i].on : 0);
			check("switching", d(4), tones[i].sw);
			check("sampling", d(5), tones[i].smp);
		end
		wr(R_PCFG, {26'h0, 6'h10});
		base = ev;
		peer.pulse(3);
		repeat (50) @(posedge clock);
		peer.pulse(4);
		repeat (20) @(posedge clock);
		check("tone cut", d(2), 52);
		wr(R_INL, 32'h1400_0003);
		wr(R_PCFG, {26'h0, 6'h08});
		peer.mode(1'b1, 1'b0);
		for (int k = 0; k < 4; k++) begin
			base = ev;
			peer.pulse(0);
			peer.send_byte(FLD_HDR0, hdr[k]);
			peer.send_byte(FLD_LEN, 8'h00);
			if (hdr[k] != 8'h00) peer.send_byte(FLD_HDR1, info[k]);
			peer.pulse(3);
			repeat (300) @(posedge clock);
			check("tone info seen", d(6), prs[k]);
			check("inline length", d(2), tlen[k]);
			check("inline samples", d(5), nsm[k]);
		end
		// advertising: flag bit0 set pushes the info octet from byte 2 to byte 8
		wr(R_INL, 32'h1400_0001);
		base = ev;
		peer.pulse(0);
		for (int j = 0; j < 9; j++) begin
			peer.send_byte(FLD_PAY, (j == 0) ? 8'h01 : (j == 1) ? 8'h05 : (j == 8) ? 8'h03 : 8'h04);
		end
		peer.pulse(3);
		repeat (300) @(posedge clock);
		check("adv info seen", d(6), 1);
		check("adv length", d(2), 240);
		wr(R_TASK, 32'h1);
		peer.send_bit(FLD_PAY, 1'b1);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk("count after reset", R_BCNT, 32'h0);
		rd_chk("inline after reset", R_INL, INL_RST);
		complete_run();
	end
endmodule
